// *** design/cfa_params.svh ***
`ifndef CFA_PARAMS_SVH
`define CFA_PARAMS_SVH

// Register offsets on the plain register port
`define CFA_FLAGS_OFS   8'h00
`define CFA_STATUS_OFS  8'h01

// Condition flag bit positions
`define CFA_BIT_V       7
`define CFA_BIT_H       4
`define CFA_BIT_I       3
`define CFA_BIT_N       2
`define CFA_BIT_Z       1
`define CFA_BIT_C       0

// Bits 6 and 5 are hard-wired high
`define CFA_FIXED_ONES  8'h60
// Reset value: mask set, fixed ones set, flags clear
`define CFA_FLAGS_RST   8'h68

// Decimal adjust corrections and limits
`define CFA_DA_LOW      8'h06
`define CFA_DA_HIGH     8'h60
`define CFA_DA_NIB_MAX  4'h9
`define CFA_DA_BYTE_MAX 8'h99

`endif

// *** design/cfa_pkg.sv ***
package cfa_pkg;

    // Flag-affecting operations
    typedef enum logic [4:0] {
        CFA_OP_ADD, CFA_OP_ADC, CFA_OP_SUB, CFA_OP_SBC, CFA_OP_AND, CFA_OP_OR,
        CFA_OP_XOR, CFA_OP_DEC, CFA_OP_DAA, CFA_OP_LD8, CFA_OP_LD16, CFA_OP_LSL,
        CFA_OP_LSR, CFA_OP_ROL, CFA_OP_ROR, CFA_OP_BTST, CFA_OP_CLRI, CFA_OP_SETI
    } cfa_op_t;

    // Operand address modes
    typedef enum logic [1:0] {
        CFA_AM_REG_ONLY, CFA_AM_PC_OFFSET, CFA_AM_INLINE, CFA_AM_DIRECT
    } cfa_mode_t;

    // Branch conditions
    typedef enum logic [3:0] {
        CFA_BR_ALWAYS, CFA_BR_SGT, CFA_BR_SGE, CFA_BR_SLE, CFA_BR_SLT,
        CFA_BR_BIT_LOW, CFA_BR_BIT_HIGH, CFA_BR_EQ, CFA_BR_NE
    } cfa_cond_t;

endpackage

// *** design/cfa_core.sv ***
`include "cfa_params.svh"
// Operation
// - Overflow flag bit 7 set on signed overflow; signed branches test it.
// - Half-carry bit 4 reflects carry from bit 3 on add operations.
// - Decimal adjust corrects prior add using half-carry and carry flags.
// - Mask bit 3 set blocks maskable interrupts; clear accepts them.
// - Interrupt mask set after registers pushed, before handler starts.
// - No interrupt recognised at boundary right after mask-clearing op.
// - Negative flag bit 2 follows bit 7 of the result.
// - Loads and stores set negative flag from the moved value's top bit.
// - Zero flag bit 1 set when result is zero, cleared otherwise.
// - Loads and stores set zero flag when moved value is all zeros.
// - Carry bit 0 set on add carry-out of bit 7 or subtract borrow.
// - Bit test, shift and rotate operations also drive carry.
// - All locations reached through one 16-bit linear address space.
// - Moves resolve source and destination with independent modes.
// - Test branches fetch operand via listed mode, target via relative.
// - Register-only mode makes no memory access for operands.
// - Relative offset sign-extended to 16 bits and added to PC.
// - Inline 16-bit operand takes high byte first, low byte next.
// - Direct mode prefixes zero high byte, reaching first 256 locations.
// - Condition bits 6 and 5 always read as one.
module cfa_core
    import cfa_pkg::*;
(
    input  wire logic             core_clk_i,   // Core clock, 250 MHz
    input  wire logic             srst_i,       // Synchronous reset, high
    input  wire logic             op_valid_i,   // Operation strobe
    input  wire cfa_pkg::cfa_op_t op_code_i,    // Operation select
    input  wire logic [7:0]       opa_i,        // Accumulator operand
    input  wire logic [7:0]       opb_i,        // Second operand
    input  wire logic [15:0]      wide_i,       // 16-bit moved value
    input  wire logic [2:0]       bit_sel_i,    // Bit number for bit test
    output logic [7:0]            result_o,     // Operation result
    output logic [7:0]            flags_o,      // Condition flags
    input  wire logic             irq_req_i,    // Maskable request pending
    input  wire logic             boundary_i,   // Instruction boundary
    input  wire logic             stack_done_i, // Registers pushed for entry
    output logic                  irq_take_o,   // Interrupt accepted pulse
    input  wire logic             addr_valid_i, // Address resolve strobe
    input  wire cfa_pkg::cfa_mode_t src_mode_i, // Source address mode
    input  wire cfa_pkg::cfa_mode_t dst_mode_i, // Destination address mode
    input  wire cfa_pkg::cfa_cond_t cond_i,     // Branch condition
    input  wire logic [15:0]      pc_i,         // Program counter
    input  wire logic [7:0]       byte1_i,      // Byte after opcode
    input  wire logic [7:0]       byte2_i,      // Second byte after opcode
    input  wire logic [7:0]       rel_i,        // Relative offset byte
    output logic [15:0]           src_ea_o,     // Source address or operand
    output logic                  src_mem_o,    // Source needs memory access
    output logic [15:0]           dst_ea_o,     // Destination address
    output logic                  dst_mem_o,    // Destination in memory
    output logic                  taken_o,      // Branch condition held
    output logic [15:0]           target_o,     // Next program counter
    input  wire logic [7:0]       reg_addr_i,   // Register address
    input  wire logic [7:0]       reg_wdata_i,  // Register write data
    input  wire logic             reg_wr_i,     // Register write strobe
    input  wire logic             reg_rd_i,     // Register read strobe
    output logic [7:0]            reg_rdata_o   // Read data, next cycle
);
    import cfa_pkg::*;

    logic [7:0]  flags_reg;
    logic [7:0]  flags_next;
    logic [7:0]  result_reg;
    logic [7:0]  result_next;
    logic        shadow_reg;
    logic        irq_take_reg;
    logic [8:0]  add_w;
    logic [8:0]  sub_w;
    logic [4:0]  half_w;
    logic        cin_w;
    logic [7:0]  da_w;
    logic        da_c_w;
    logic        cond_w;
    logic        mask_clear_w;

    // Carry-in for chained arithmetic
    assign cin_w = (op_code_i == CFA_OP_ADC || op_code_i == CFA_OP_SBC)
                   ? flags_reg[`CFA_BIT_C] : 1'b0;
    assign add_w  = {1'b0, opa_i} + {1'b0, opb_i} + {8'h00, cin_w};
    assign sub_w  = {1'b0, opa_i} - {1'b0, opb_i} - {8'h00, cin_w};
    assign half_w = {1'b0, opa_i[3:0]} + {1'b0, opb_i[3:0]} + {4'h0, cin_w};

    // Decimal correction of a previous add result
    always_comb
    begin
        da_w   = 8'h00;
        da_c_w = flags_reg[`CFA_BIT_C];
        if (flags_reg[`CFA_BIT_H] || opa_i[3:0] > `CFA_DA_NIB_MAX)
            da_w = da_w | `CFA_DA_LOW;
        if (flags_reg[`CFA_BIT_C] || opa_i > `CFA_DA_BYTE_MAX)
        begin
            da_w   = da_w | `CFA_DA_HIGH;
            da_c_w = 1'b1;
        end
    end

    // Result and flag update per operation; untouched bits hold
    always_comb
    begin
        flags_next  = flags_reg;
        result_next = result_reg;
        if (op_valid_i)
        begin
            unique case (op_code_i)
                CFA_OP_ADD, CFA_OP_ADC:
                begin
                    result_next = add_w[7:0];
                    flags_next[`CFA_BIT_H] = half_w[4];
                    flags_next[`CFA_BIT_C] = add_w[8];
                    flags_next[`CFA_BIT_V] = (opa_i[7] == opb_i[7])
                                             && (add_w[7] != opa_i[7]);
                end
                CFA_OP_SUB, CFA_OP_SBC:
                begin
                    result_next = sub_w[7:0];
                    flags_next[`CFA_BIT_C] = sub_w[8];
                    flags_next[`CFA_BIT_V] = (opa_i[7] != opb_i[7])
                                             && (sub_w[7] != opa_i[7]);
                end
                CFA_OP_AND:  result_next = opa_i & opb_i;
                CFA_OP_OR:   result_next = opa_i | opb_i;
                CFA_OP_XOR:  result_next = opa_i ^ opb_i;
                CFA_OP_DEC:
                begin
                    result_next = opa_i - 8'h01;
                    flags_next[`CFA_BIT_V] = (opa_i == 8'h80);
                end
                CFA_OP_DAA:
                begin
                    result_next = opa_i + da_w;
                    flags_next[`CFA_BIT_C] = da_c_w;
                end
                CFA_OP_LD8, CFA_OP_LD16: result_next = opa_i;
                CFA_OP_LSL:
                begin
                    result_next = {opa_i[6:0], 1'b0};
                    flags_next[`CFA_BIT_C] = opa_i[7];
                end
                CFA_OP_LSR:
                begin
                    result_next = {1'b0, opa_i[7:1]};
                    flags_next[`CFA_BIT_C] = opa_i[0];
                end
                CFA_OP_ROL:
                begin
                    result_next = {opa_i[6:0], flags_reg[`CFA_BIT_C]};
                    flags_next[`CFA_BIT_C] = opa_i[7];
                end
                CFA_OP_ROR:
                begin
                    result_next = {flags_reg[`CFA_BIT_C], opa_i[7:1]};
                    flags_next[`CFA_BIT_C] = opa_i[0];
                end
                CFA_OP_BTST: flags_next[`CFA_BIT_C] = opa_i[bit_sel_i];
                CFA_OP_CLRI: flags_next[`CFA_BIT_I] = 1'b0;
                CFA_OP_SETI: flags_next[`CFA_BIT_I] = 1'b1;
                default: ;
            endcase
            // N and Z from the value produced or moved
            if (op_code_i == CFA_OP_LD16)
            begin
                flags_next[`CFA_BIT_N] = wide_i[15];
                flags_next[`CFA_BIT_Z] = (wide_i == 16'h0000);
            end
            else if (op_code_i == CFA_OP_LD8)
            begin
                flags_next[`CFA_BIT_N] = opa_i[7];
                flags_next[`CFA_BIT_Z] = (opa_i == 8'h00);
            end
            else if (op_code_i != CFA_OP_BTST && op_code_i != CFA_OP_CLRI
                     && op_code_i != CFA_OP_SETI)
            begin
                flags_next[`CFA_BIT_N] = result_next[7];
                flags_next[`CFA_BIT_Z] = (result_next == 8'h00);
            end
        end
        else if (reg_wr_i && reg_addr_i == `CFA_FLAGS_OFS)
            flags_next = reg_wdata_i;
        // Stack push completion sets the mask, winning over a clear
        if (stack_done_i)
            flags_next[`CFA_BIT_I] = 1'b1;
        flags_next = flags_next | `CFA_FIXED_ONES;
    end

    // Mask going from set to clear by an operation or a write
    assign mask_clear_w = flags_reg[`CFA_BIT_I] && !flags_next[`CFA_BIT_I];

    // Flag and result registers
    always_ff @(posedge core_clk_i)
    begin
        if (srst_i)
        begin
            flags_reg  <= `CFA_FLAGS_RST;
            result_reg <= 8'h00;
        end
        else
        begin
            flags_reg  <= flags_next;
            result_reg <= result_next;
        end
    end

    // Shadow boundary after the mask is cleared
    always_ff @(posedge core_clk_i)
    begin
        if (srst_i)
            shadow_reg <= 1'b0;
        else if (mask_clear_w)
            shadow_reg <= 1'b1;
        else if (boundary_i)
            shadow_reg <= 1'b0;
    end

    // Interrupt recognition at boundaries
    always_ff @(posedge core_clk_i)
    begin
        if (srst_i)
            irq_take_reg <= 1'b0;
        else
            irq_take_reg <= boundary_i && irq_req_i && !flags_reg[`CFA_BIT_I]
                            && !shadow_reg && !stack_done_i;
    end

    // Branch condition from flags, signed ones via overflow
    always_comb
    begin
        unique case (cond_i)
            CFA_BR_ALWAYS:   cond_w = 1'b1;
            CFA_BR_SGT:      cond_w = !(flags_reg[`CFA_BIT_Z] || (flags_reg[`CFA_BIT_N]
                                      ^ flags_reg[`CFA_BIT_V]));
            CFA_BR_SGE:      cond_w = !(flags_reg[`CFA_BIT_N] ^ flags_reg[`CFA_BIT_V]);
            CFA_BR_SLE:      cond_w = flags_reg[`CFA_BIT_Z] || (flags_reg[`CFA_BIT_N]
                                      ^ flags_reg[`CFA_BIT_V]);
            CFA_BR_SLT:      cond_w = flags_reg[`CFA_BIT_N] ^ flags_reg[`CFA_BIT_V];
            CFA_BR_BIT_LOW:  cond_w = !flags_reg[`CFA_BIT_C];
            CFA_BR_BIT_HIGH: cond_w = flags_reg[`CFA_BIT_C];
            CFA_BR_EQ:       cond_w = flags_reg[`CFA_BIT_Z];
            CFA_BR_NE:       cond_w = !flags_reg[`CFA_BIT_Z];
            default:         cond_w = 1'b0;
        endcase
    end

    // Resolve one operand location from a mode, in one 16-bit space
    function automatic logic [16:0] cfa_resolve(input cfa_mode_t mode,
                                               input logic [15:0] pc,
                                               input logic [7:0] b1,
                                               input logic [7:0] b2);
        logic [16:0] r;
        r = 17'h00000;
        unique case (mode)
            CFA_AM_REG_ONLY:  r = 17'h00000;
            CFA_AM_PC_OFFSET: r = {1'b0, pc + {{8{b1[7]}}, b1}};
            CFA_AM_INLINE:    r = {1'b0, b1, b2};
            CFA_AM_DIRECT:    r = {1'b1, 8'h00, b1};
        endcase
        return r;
    endfunction

    logic [16:0] src_w;
    logic [16:0] dst_w;
    assign src_w = cfa_resolve(src_mode_i, pc_i, byte1_i, byte2_i);
    assign dst_w = cfa_resolve(dst_mode_i, pc_i, byte2_i, 8'h00);

    // Address and branch outputs, target via relative offset when taken, else PC
    always_ff @(posedge core_clk_i)
    begin
        if (srst_i)
        begin
            src_ea_o  <= 16'h0000;
            src_mem_o <= 1'b0;
            dst_ea_o  <= 16'h0000;
            dst_mem_o <= 1'b0;
            taken_o   <= 1'b0;
            target_o  <= 16'h0000;
        end
        else if (addr_valid_i)
        begin
            src_ea_o  <= src_w[15:0];
            src_mem_o <= src_w[16];
            dst_ea_o  <= dst_w[15:0];
            dst_mem_o <= dst_w[16];
            taken_o   <= cond_w;
            target_o  <= cond_w ? pc_i + {{8{rel_i[7]}}, rel_i} : pc_i;
        end
    end

    // Register read port, data one cycle after the strobe
    always_ff @(posedge core_clk_i)
    begin
        if (srst_i)
            reg_rdata_o <= 8'h00;
        else if (reg_rd_i && reg_addr_i == `CFA_FLAGS_OFS)
            reg_rdata_o <= flags_reg;
        else if (reg_rd_i && reg_addr_i == `CFA_STATUS_OFS)
            reg_rdata_o <= {6'h00, irq_req_i, shadow_reg};
        else
            reg_rdata_o <= 8'h00;
    end

    assign result_o   = result_reg;
    assign flags_o    = flags_reg;
    assign irq_take_o = irq_take_reg;

    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (srst_i);

    sequence s_mask_cleared;
        $fell(flags_reg[`CFA_BIT_I]);
    endsequence
    // First boundary arriving one cycle after the clear is seen
    sequence s_first_boundary;
        !boundary_i ##1 boundary_i;
    endsequence

    chk_fixed_ones_high: assert property (flags_o[6:5] == 2'b11)
        else $error("fixed condition bits not high");
    chk_mask_blocks_irq: assert property (flags_reg[`CFA_BIT_I] |=> !irq_take_reg)
        else $error("interrupt taken while masked");
    chk_shadow_no_irq: assert property (s_mask_cleared ##0 s_first_boundary
        |=> !irq_take_reg)
        else $error("interrupt taken right after mask clear");
    chk_push_sets_mask: assert property (stack_done_i |=> flags_reg[`CFA_BIT_I])
        else $error("mask not set after push");
    chk_add_half_carry: assert property (op_valid_i && op_code_i == CFA_OP_ADD |=>
        flags_reg[`CFA_BIT_H] == (($past(opa_i[3:0]) + $past(opb_i[3:0])) > 5'h0F))
        else $error("half-carry wrong after add");
    chk_add_carry_out: assert property (op_valid_i && op_code_i == CFA_OP_ADD |=>
        flags_reg[`CFA_BIT_C] == (({1'b0, $past(opa_i)} + $past(opb_i)) > 9'h0FF))
        else $error("carry wrong after add");
    chk_load_wide_nz: assert property (op_valid_i && op_code_i == CFA_OP_LD16 |=>
        flags_reg[`CFA_BIT_N] == $past(wide_i[15])
        && flags_reg[`CFA_BIT_Z] == ($past(wide_i) == 16'h0000))
        else $error("load flags wrong");
    chk_result_zero_flag: assert property (op_valid_i && op_code_i == CFA_OP_XOR |=>
        flags_reg[`CFA_BIT_Z] == (($past(opa_i) ^ $past(opb_i)) == 8'h00)
        && flags_reg[`CFA_BIT_N] == ($past(opa_i[7]) ^ $past(opb_i[7])))
        else $error("zero or negative flag wrong");
    chk_direct_page: assert property (addr_valid_i && src_mode_i == CFA_AM_DIRECT |=>
        src_ea_o[15:8] == 8'h00 && src_mem_o)
        else $error("direct address outside first page");
    chk_reg_only_nomem: assert property (addr_valid_i && src_mode_i == CFA_AM_REG_ONLY
        |=> !src_mem_o)
        else $error("register-only mode touched memory");
    chk_signed_branch: assert property (addr_valid_i && cond_i == CFA_BR_SLT |=>
        taken_o == ($past(flags_reg[`CFA_BIT_N]) ^ $past(flags_reg[`CFA_BIT_V])))
        else $error("signed branch ignores overflow");
    chk_logic_keeps_carry: assert property (op_valid_i && op_code_i == CFA_OP_AND
        && !stack_done_i |=> $stable(flags_reg[`CFA_BIT_C]))
        else $error("logic op changed carry");

endmodule

// *** tb/cfa_mem_model.sv ***
// Memory bus model supplying the bytes that follow an opcode
module cfa_mem_model (
    input  wire logic [15:0] pc_i,    // Opcode address
    output logic [7:0]       byte1_o, // Byte after opcode
    output logic [7:0]       byte2_o  // Second byte after opcode
);
    timeunit 1ns;
    timeprecision 1ps;

    // Program image around the test opcode; other places read a pattern
    // that changes with the address, with no start-up race
    function automatic logic [7:0] rd(input logic [15:0] a);
        case (a)
            16'h1001: return 8'hFE;
            16'h1002: return 8'h34;
            default:  return ~a[7:0];
        endcase
    endfunction

    // Operand bytes, high byte first in object order
    assign byte1_o = rd(pc_i + 16'h0001);
    assign byte2_o = rd(pc_i + 16'h0002);
endmodule

// *** tb/tb.sv ***
`define CHK(got, exp) begin n_tests++; if ((got) !== (exp)) begin n_fail++; \
    $display("Error at %0t: got %h expected %h", $time, got, exp); end end

module tb;
    timeunit 1ns;
    timeprecision 1ps;
    import cfa_pkg::*;

    typedef struct {
        cfa_op_t    op;
        logic [7:0] a;
        logic [7:0] b;
        logic [2:0] bs;
        logic [7:0] res;
        logic       cr;
        logic [7:0] fl;
    } cfa_row_t;

    logic       core_clk_i = 0;
    logic       srst_i = 1;
    logic       op_valid_i = 0;
    cfa_op_t    op_code_i = CFA_OP_ADD;
    logic [7:0] opa_i = 0, opb_i = 0, byte1, byte2, result, flags, rdata;
    logic [15:0] wide_i = 0, src_ea, dst_ea, target;
    logic [2:0] bit_sel_i = 0;
    logic       irq_req_i = 0, boundary_i = 0, stack_done_i = 0, addr_valid_i = 0;
    logic       irq_take, src_mem, dst_mem, taken;
    cfa_mode_t  src_mode_i = CFA_AM_REG_ONLY, dst_mode_i = CFA_AM_DIRECT;
    cfa_cond_t  cond_i = CFA_BR_ALWAYS;
    logic [7:0] reg_addr_i = 0, reg_wdata_i = 0;
    logic       reg_wr_i = 0, reg_rd_i = 0;
    int         n_fail = 0, n_tests = 0;
    cfa_row_t   rows [20];
    logic [15:0] ea_exp [4] = '{16'h0000, 16'h0FFE, 16'hFE34, 16'h00FE};
    logic [15:0] dst_exp [4] = '{16'h0000, 16'h1034, 16'h3400, 16'h0034};

    cfa_core u_cfa_core (.core_clk_i(core_clk_i), .srst_i(srst_i), .op_valid_i(op_valid_i),
        .op_code_i(op_code_i), .opa_i(opa_i), .opb_i(opb_i), .wide_i(wide_i),
        .bit_sel_i(bit_sel_i), .result_o(result), .flags_o(flags), .irq_req_i(irq_req_i),
        .boundary_i(boundary_i), .stack_done_i(stack_done_i), .irq_take_o(irq_take),
        .addr_valid_i(addr_valid_i), .src_mode_i(src_mode_i), .dst_mode_i(dst_mode_i),
        .cond_i(cond_i), .pc_i(16'h1000), .byte1_i(byte1), .byte2_i(byte2), .rel_i(byte1),
        .src_ea_o(src_ea), .src_mem_o(src_mem), .dst_ea_o(dst_ea), .dst_mem_o(dst_mem),
        .taken_o(taken), .target_o(target), .reg_addr_i(reg_addr_i),
        .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
        .reg_rdata_o(rdata));

    cfa_mem_model u_mem (.pc_i(16'h1000), .byte1_o(byte1), .byte2_o(byte2));

    // Clock, 4 ns period
    initial
    begin
        forever #2 core_clk_i = ~core_clk_i;
    end

    task automatic test_done();
        $display("Comparisons %0d, mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    // One operation, outputs checked after the taking edge
    task automatic do_op(cfa_op_t op, logic [7:0] a, logic [7:0] b, logic [2:0] bs);
        @(posedge core_clk_i);
        op_valid_i <= 1; op_code_i <= op; opa_i <= a; opb_i <= b; bit_sel_i <= bs;
        @(posedge core_clk_i);
        op_valid_i <= 0;
        #1;
    endtask

    task automatic reg_write(logic [7:0] a, logic [7:0] d);
        @(posedge core_clk_i);
        reg_wr_i <= 1; reg_addr_i <= a; reg_wdata_i <= d;
        @(posedge core_clk_i);
        reg_wr_i <= 0;
    endtask

    // Read data stands only in the cycle after the strobe
    task automatic reg_read(logic [7:0] a, output logic [7:0] d);
        @(posedge core_clk_i);
        reg_rd_i <= 1; reg_addr_i <= a;
        @(posedge core_clk_i);
        reg_rd_i <= 0;
        #1 d = rdata;
    endtask

    // One-cycle pulse on the boundary input, or on push-done when push is set
    task automatic pulse(bit push);
        @(posedge core_clk_i);
        if (push)
            stack_done_i <= 1;
        else
            boundary_i <= 1;
        @(posedge core_clk_i);
        stack_done_i <= 0;
        boundary_i <= 0;
        #1;
    endtask

    task automatic resolve(cfa_mode_t m, cfa_cond_t c, cfa_mode_t dm);
        @(posedge core_clk_i);
        addr_valid_i <= 1; src_mode_i <= m; cond_i <= c; dst_mode_i <= dm;
        @(posedge core_clk_i);
        addr_valid_i <= 0;
        #1;
    endtask

    // Branch outcome from the flag byte
    function automatic logic br_exp(cfa_cond_t c, logic [7:0] f);
        logic nv;
        nv = f[2] ^ f[7];
        case (c)
            CFA_BR_SGT:      return !(f[1] | nv);
            CFA_BR_SGE:      return !nv;
            CFA_BR_SLE:      return f[1] | nv;
            CFA_BR_SLT:      return nv;
            CFA_BR_BIT_LOW:  return !f[0];
            CFA_BR_BIT_HIGH: return f[0];
            CFA_BR_EQ:       return f[1];
            CFA_BR_NE:       return !f[1];
            default:         return 1'b1;
        endcase
    endfunction

    task automatic branches(logic [7:0] f);
        for (int c = 0; c < 9; c++)
        begin
            resolve(CFA_AM_PC_OFFSET, cfa_cond_t'(c), CFA_AM_DIRECT);
            `CHK(taken, br_exp(cfa_cond_t'(c), f))
            `CHK(target, br_exp(cfa_cond_t'(c), f) ? 16'h0FFE : 16'h1000)
        end
    endtask

    // Watchdog, far beyond the roughly 150 cycles the tests need
    initial
    begin
        #20000;
        n_fail++;
        $display("Error at %0t: watchdog expired", $time);
        test_done();
    end

    initial
    begin
        logic [7:0] d;
        rows = '{
            '{CFA_OP_ADD, 8'h08, 8'h08, 3'h0, 8'h10, 1'b1, 8'h78},
            '{CFA_OP_ADD, 8'h80, 8'h80, 3'h0, 8'h00, 1'b1, 8'hEB},
            '{CFA_OP_ADC, 8'h01, 8'h01, 3'h0, 8'h03, 1'b1, 8'h68},
            '{CFA_OP_SUB, 8'h00, 8'h01, 3'h0, 8'hFF, 1'b1, 8'h6D},
            '{CFA_OP_SBC, 8'h05, 8'h02, 3'h0, 8'h02, 1'b1, 8'h68},
            '{CFA_OP_AND, 8'hF0, 8'h0F, 3'h0, 8'h00, 1'b1, 8'h6A},
            '{CFA_OP_OR,  8'h80, 8'h01, 3'h0, 8'h81, 1'b1, 8'h6C},
            '{CFA_OP_XOR, 8'hFF, 8'hFF, 3'h0, 8'h00, 1'b1, 8'h6A},
            '{CFA_OP_ADD, 8'h09, 8'h08, 3'h0, 8'h11, 1'b1, 8'h78},
            '{CFA_OP_DAA, 8'h11, 8'h00, 3'h0, 8'h17, 1'b1, 8'h78},
            '{CFA_OP_ADD, 8'h99, 8'h01, 3'h0, 8'h9A, 1'b1, 8'h6C},
            '{CFA_OP_DAA, 8'h9A, 8'h00, 3'h0, 8'h00, 1'b1, 8'h6B},
            '{CFA_OP_LD8, 8'h80, 8'h00, 3'h0, 8'h80, 1'b1, 8'h6D},
            '{CFA_OP_LSL, 8'h81, 8'h00, 3'h0, 8'h02, 1'b1, 8'h69},
            '{CFA_OP_LSR, 8'h01, 8'h00, 3'h0, 8'h00, 1'b1, 8'h6B},
            '{CFA_OP_ROL, 8'h80, 8'h00, 3'h0, 8'h01, 1'b1, 8'h69},
            '{CFA_OP_ROR, 8'h02, 8'h00, 3'h0, 8'h81, 1'b1, 8'h6C},
            '{CFA_OP_BTST, 8'h10, 8'h00, 3'h4, 8'h00, 1'b0, 8'h6D},
            '{CFA_OP_DEC, 8'h80, 8'h00, 3'h0, 8'h7F, 1'b1, 8'hE9},
            '{CFA_OP_SETI, 8'h00, 8'h00, 3'h0, 8'h00, 1'b0, 8'hE9}};
        repeat (2) @(posedge core_clk_i);
        srst_i <= 0;
        #1;
        `CHK(flags, 8'h68)
        `CHK(result, 8'h00)
        $display("test reset done");
        // Chained rows, each starting from the flags the previous row left
        foreach (rows[i])
        begin
            do_op(rows[i].op, rows[i].a, rows[i].b, rows[i].bs);
            if (rows[i].cr)
                `CHK(result, rows[i].res)
            `CHK(flags, rows[i].fl)
        end
        $display("test operation table done");
        wide_i <= 16'h8000;
        do_op(CFA_OP_LD16, 8'h00, 8'h00, 3'h0);
        `CHK(flags, 8'hED)
        wide_i <= 16'h0000;
        do_op(CFA_OP_LD16, 8'h00, 8'h00, 3'h0);
        `CHK(flags, 8'hEB)
        $display("test wide load done");
        // Masked request, then the boundary right after clearing the mask
        irq_req_i <= 1;
        pulse(1'b0);
        `CHK(irq_take, 1'b0)
        do_op(CFA_OP_CLRI, 8'h00, 8'h00, 3'h0);
        `CHK(flags, 8'hE3)
        pulse(1'b0);
        `CHK(irq_take, 1'b0)
        pulse(1'b0);
        `CHK(irq_take, 1'b1)
        @(posedge core_clk_i);
        #1 `CHK(irq_take, 1'b0)
        pulse(1'b1);
        `CHK(flags, 8'hEB)
        $display("test interrupt done");
        reg_read(8'h00, d);
        `CHK(d, 8'hEB)
        reg_read(8'h01, d);
        `CHK(d, 8'h02)
        reg_write(8'h00, 8'h9F);
        reg_read(8'h00, d);
        `CHK(d, 8'hFF)
        reg_write(8'h00, 8'h00);
        reg_write(8'h7F, 8'h33);
        reg_read(8'h7F, d);
        `CHK(d, 8'h00)
        reg_read(8'h01, d);
        `CHK(d, 8'h03)
        `CHK(flags, 8'h60)
        $display("test register port done");
        // Every source mode against a different destination mode each time
        for (int m = 0; m < 4; m++)
        begin
            resolve(cfa_mode_t'(m), CFA_BR_ALWAYS, cfa_mode_t'(3 - m));
            `CHK(src_ea, ea_exp[m])
            `CHK(src_mem, (m == 3))
            `CHK(dst_ea, dst_exp[3 - m])
            `CHK(dst_mem, (m == 0))
        end
        $display("test address modes done");
        branches(8'h60);
        reg_write(8'h00, 8'h80);
        branches(8'hE0);
        reg_write(8'h00, 8'h07);
        branches(8'h67);
        $display("test branches done");
        // Mid-run reset puts flags, source address and branch target back to their reset values
        @(posedge core_clk_i);
        srst_i <= 1;
        repeat (2) @(posedge core_clk_i);
        srst_i <= 0;
        #1;
        `CHK(flags, 8'h68)
        `CHK(src_ea, 16'h0000)
        `CHK(target, 16'h0000)
        $display("test mid-run reset done");
        test_done();
    end
endmodule
